// ===== rtl/ivf_map.svh
`ifndef IVF_MAP_SVH
`define IVF_MAP_SVH
// register offsets
`define IVF_TALLY_OFS   16'h12fc
`define IVF_TALLY_RST   32'h0000_0000
// header field values
`define IVF_TAG_VIDEO   2'h0
`define IVF_TCODE_ISO   4'ha
`define IVF_SY_FIRST    4'h1
`define IVF_SY_OTHER    4'h0
// crc constants
`define IVF_CRC_POLY    32'h04c1_1db7
`define IVF_CRC_INIT    32'hffff_ffff
// payload sizing: rate code of the 30 fps reference column, partial-image format
`define IVF_RATE_REF    3'h4
`define IVF_FMT_PART    3'h7
`define IVF_QMAX        17'h03fff
// largest payload in quadlets at the lowest speed, doubling per speed step
`define IVF_S100_QMAX   17'h00100
`endif

// ===== rtl/ivf_pkg.sv
package ivf_pkg;
    // one image quadlet with its start-of-frame marker
    typedef struct packed {
        logic        sof;
        logic [31:0] data;
    } ivf_pix_s;

    // first quadlet of an isochronous block
    typedef struct packed {
        logic [15:0] len;
        logic [1:0]  tag;
        logic [5:0]  chan;
        logic [3:0]  tcode;
        logic [3:0]  sy;
    } ivf_hdr_s;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_HCRC = 5'b00010,
        ST_PAY  = 5'b00100,
        ST_DCRC = 5'b01000,
        ST_DONE = 5'b10000
    } ivf_state_e;
endpackage

// ===== rtl/ivf_buf2.sv
`timescale 1ns/1ps
module ivf_buf2
    import ivf_pkg::*;
(
    input  wire logic     i_sys_clk,
    input  wire logic     i_rst_n,
    input  wire logic     i_in_valid,
    input  ivf_pix_s      i_in_data,
    output logic          o_in_ready,
    output logic          o_out_valid,
    output ivf_pix_s      o_out_data,
    input  wire logic     i_out_ready
);
    ivf_pix_s   mem [2];
    logic       wr_ptr;
    logic       rd_ptr;
    logic [1:0] cnt;
    wire        push = i_in_valid && o_in_ready;
    wire        pop  = o_out_valid && i_out_ready;
    wire  [1:0] next_cnt = cnt + {1'b0, push} - {1'b0, pop};

    assign o_out_valid = (cnt != 2'h0);
    assign o_out_data  = mem[rd_ptr];

    // ready is registered so the source sees a clean flop
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt        <= 2'h0;
            wr_ptr     <= 1'b0;
            rd_ptr     <= 1'b0;
            o_in_ready <= 1'b0;
        end else begin
            cnt        <= next_cnt;
            wr_ptr     <= wr_ptr ^ push;
            rd_ptr     <= rd_ptr ^ pop;
            o_in_ready <= (next_cnt != 2'h2);
        end
    end

    // storage needs no reset
    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    a_buf_no_overfill: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        cnt != 2'h3) else $error("buffer count out of range");
endmodule

// ===== rtl/ivf_framer.sv
`timescale 1ns/1ps
`include "ivf_map.svh"
// Notes on behaviour
// - 32-bit tally of failed frames; read returns it, a write to its offset clears it.
// - frame fails when arbitration is lost and the image buffer overflows.
// - video leaves only as isochronous blocks; registers use the separate port.
// - no block is sent until isochronous bandwidth has been allocated.
// - header length field holds byte count of the data field.
// - header tag field is always zero.
// - header channel field is the software-programmed isochronous channel.
// - header transaction code is the isochronous data block code.
// - sync field is one on a frame's first block, zero otherwise.
// - payload carries only image quadlets of the current frame; ST_PAY ignores sof, so a block can run into the next frame.
// - quadlets per period follow format, mode and frame rate.
// - partial-image format takes its size from the negotiated value input.
// - sizes are counted in quadlets per packet.
// - a block is sent only if the bus speed covers its size.
module ivf_framer
    import ivf_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rstn,
    // register access, carried by asynchronous transactions
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [15:0] i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    output logic      [31:0] o_reg_rdata,
    // video settings
    input  wire logic [2:0]  i_fmt,
    input  wire logic [2:0]  i_mode,
    input  wire logic [2:0]  i_rate,
    input  wire logic [13:0] i_part_quads,
    input  wire logic [5:0]  i_iso_chan,
    input  wire logic [2:0]  i_iso_speed,
    input  wire logic        i_iso_en,
    input  wire logic        i_bw_alloc,
    // bus timing and arbitration
    input  wire logic        i_cycle_start,
    input  wire logic        i_arb_grant,
    // image source
    input  wire logic        i_pix_valid,
    input  wire logic        i_pix_sof,
    input  wire logic [31:0] i_pix_data,
    output logic             o_pix_ready,
    // isochronous quadlet stream to the link
    output logic             o_tx_valid,
    output logic      [31:0] o_tx_data,
    output logic             o_tx_last,
    input  wire logic        i_tx_ready
);
    // one crc-32 step over a quadlet, msb first
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 31; i >= 0; i--) begin
            r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? `IVF_CRC_POLY : 32'h0);
        end
        return r;
    endfunction

    // quadlets per period at 30 fps, then scaled by rate
    function automatic logic [16:0] quads_for(input logic [2:0] f, input logic [2:0] m,
                                              input logic [2:0] r);
        logic [16:0] b;
        b = 17'h0;
        if (f == 3'h0) begin
            case (m)
                3'h0: b = 17'h0003c;
                3'h1: b = 17'h000a0;
                3'h2: b = 17'h001e0;
                3'h3: b = 17'h00280;
                3'h4: b = 17'h003c0;
                3'h5: b = 17'h00140;
                3'h6: b = 17'h00280;
                default: b = 17'h0;
            endcase
        end else if (f == 3'h1) begin
            case (m)
                3'h0: b = 17'h003e8;
                3'h1: b = 17'h005dc;
                3'h2: b = 17'h001f4;
                3'h3: b = 17'h00600;
                3'h4: b = 17'h00900;
                3'h5: b = 17'h00300;
                3'h6: b = 17'h003e8;
                default: b = 17'h00600;
            endcase
        end
        if (r >= `IVF_RATE_REF) begin
            b = b << (r - `IVF_RATE_REF);
        end else begin
            b = b >> (`IVF_RATE_REF - r);
        end
        return b;
    endfunction

    // reset release through two flops
    logic rst_meta, rst_n;
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // two-entry buffer in the image path
    ivf_pix_s buf_in, buf_out;
    logic     buf_valid, buf_pop;
    assign buf_in = '{sof: i_pix_sof, data: i_pix_data};
    ivf_buf2 u_buf (
        .i_sys_clk   (i_sys_clk),
        .i_rst_n     (rst_n),
        .i_in_valid  (i_pix_valid),
        .i_in_data   (buf_in),
        .o_in_ready  (o_pix_ready),
        .o_out_valid (buf_valid),
        .o_out_data  (buf_out),
        .i_out_ready (buf_pop)
    );

    // payload sizing and speed check
    wire [16:0] tab_q   = quads_for(i_fmt, i_mode, i_rate);
    wire [16:0] per_q   = (i_fmt == `IVF_FMT_PART) ? {3'h0, i_part_quads} : tab_q;
    wire        q_ok    = (per_q != 17'h0) && (per_q <= `IVF_QMAX);
    wire [16:0] spd_max = `IVF_S100_QMAX << i_iso_speed;
    wire        spd_ok  = (per_q <= spd_max);

    ivf_state_e st, next_st;
    ivf_hdr_s   hdr_q;
    logic [13:0] quads, rem;
    logic [31:0] crc_acc;
    logic [31:0] tally;
    logic        frame_lost;

    wire out_free = !o_tx_valid || i_tx_ready;
    // bandwidth, enable, grant and a waiting quadlet must all hold at period start
    wire launch = (st == ST_IDLE) && out_free && i_cycle_start && i_iso_en
                  && i_bw_alloc && i_arb_grant && buf_valid && q_ok && spd_ok;
    assign buf_pop = (st == ST_PAY) && out_free;

    // header built from live settings at launch
    ivf_hdr_s hdr_new;
    // one assignment for the whole struct keeps it a single driver
    assign hdr_new = '{len:   {per_q[13:0], 2'b00},
                       tag:   `IVF_TAG_VIDEO,
                       chan:  i_iso_chan,
                       tcode: `IVF_TCODE_ISO,
                       sy:    buf_out.sof ? `IVF_SY_FIRST : `IVF_SY_OTHER};

    // block sequencer
    always_comb begin
        next_st = st;
        case (st)
            ST_IDLE: if (launch) next_st = ST_HCRC;
            ST_HCRC: if (out_free) next_st = ST_PAY;
            ST_PAY:  if (out_free && buf_valid && rem == 14'h1) next_st = ST_DCRC;
            ST_DCRC: if (out_free) next_st = ST_DONE;
            ST_DONE: next_st = ST_IDLE;
            default: next_st = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // output quadlet register; holds while the link stalls
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_tx_valid <= 1'b0;
            o_tx_data  <= 32'h0;
            o_tx_last  <= 1'b0;
            hdr_q      <= '0;
            quads      <= 14'h0;
            rem        <= 14'h0;
            crc_acc    <= `IVF_CRC_INIT;
        end else if (out_free) begin
            o_tx_valid <= 1'b0;
            o_tx_last  <= 1'b0;
            if (launch) begin
                o_tx_valid <= 1'b1;
                o_tx_data  <= hdr_new;
                hdr_q      <= hdr_new;
                quads      <= per_q[13:0];
                rem        <= per_q[13:0];
            end else if (st == ST_HCRC) begin
                o_tx_valid <= 1'b1;
                o_tx_data  <= ~crc_step(`IVF_CRC_INIT, hdr_q);
                crc_acc    <= `IVF_CRC_INIT;
            end else if (st == ST_PAY && buf_valid) begin
                o_tx_valid <= 1'b1;
                o_tx_data  <= buf_out.data;
                crc_acc    <= crc_step(crc_acc, buf_out.data);
                rem        <= rem - 14'h1;
            end else if (st == ST_DCRC) begin
                o_tx_valid <= 1'b1;
                o_tx_data  <= ~crc_acc;
                o_tx_last  <= 1'b1;
            end
        end
    end

    // failure tally: one count per frame that overflows without the bus
    wire overflow  = i_pix_valid && !o_pix_ready;
    wire tally_inc = overflow && !i_arb_grant && !frame_lost;
    wire tally_hit = i_reg_wr && (i_reg_addr == `IVF_TALLY_OFS);
    wire new_frame = i_pix_valid && o_pix_ready && i_pix_sof;

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tally      <= `IVF_TALLY_RST;
            frame_lost <= 1'b0;
        end else begin
            // an increment in the clearing cycle survives as one
            if (tally_hit) begin
                tally <= tally_inc ? 32'h1 : `IVF_TALLY_RST;
            end else if (tally_inc) begin
                tally <= tally + 32'h1;
            end
            if (tally_inc) begin
                frame_lost <= 1'b1;
            end else if (new_frame) begin
                frame_lost <= 1'b0;
            end
        end
    end

    // register read port; unmapped offsets read zero
    wire [31:0] rd_mux = (i_reg_addr == `IVF_TALLY_OFS) ? tally : 32'h0;
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_reg_rdata <= 32'h0;
        end else if (i_reg_rd) begin
            o_reg_rdata <= rd_mux;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_hdr_out;
        st == ST_HCRC && o_tx_valid;
    endsequence

    a_hdr_tag_zero: assert property (s_hdr_out |-> o_tx_data[15:14] == 2'h0)
        else $error("header tag not zero");
    a_hdr_tcode: assert property (s_hdr_out |-> o_tx_data[7:4] == 4'ha)
        else $error("header tcode wrong");
    a_hdr_length: assert property (s_hdr_out |-> o_tx_data[31:16] == {quads, 2'b00})
        else $error("length does not match payload");
    a_hdr_channel: assert property (launch |=> o_tx_data[13:8] == $past(i_iso_chan))
        else $error("channel not the programmed one");
    a_sync_first: assert property (launch |=> o_tx_data[3:0] == {3'h0, $past(buf_out.sof)})
        else $error("sync field wrong");
    a_hcrc_next: assert property (st == ST_HCRC && out_free |=>
        o_tx_valid && o_tx_data == ~crc_step(32'hffff_ffff, hdr_q))
        else $error("header crc missing");
    a_no_bw_hold: assert property (st == ST_IDLE && !i_bw_alloc |=> st == ST_IDLE)
        else $error("block sent without bandwidth");
    a_tally_clear: assert property (tally_hit && !tally_inc |=> tally == 32'h0)
        else $error("write did not clear tally");
    a_tally_count: assert property (tally_inc && !tally_hit |=> tally == $past(tally) + 32'h1)
        else $error("tally did not count failure");
    a_last_crc: assert property (o_tx_valid && o_tx_last |-> st == ST_DONE || st == ST_IDLE)
        else $error("last flag outside data crc");
endmodule

// ===== dv/ivf_link_model.sv
`timescale 1ns/1ps
// far side: link layer plus resource manager of the bus
module ivf_link_model #(
    parameter int PERIOD = 128
) (
    input  wire logic i_sys_clk,
    input  wire logic i_stall,
    input  wire logic i_bw_req,
    output logic      o_cycle_start,
    output logic      o_bw_alloc,
    output logic      o_tx_ready
);
    logic [7:0]  cnt  = 8'h00;
    logic [15:0] lfsr = 16'hace1;

    initial begin
        o_cycle_start = 1'b0;
        o_bw_alloc    = 1'b0;
        o_tx_ready    = 1'b1;
    end

    // period pulses, allocation answer, and a ready that stalls at random when asked
    always @(negedge i_sys_clk) begin
        o_bw_alloc    <= i_bw_req;
        cnt           <= (cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
        o_cycle_start <= (cnt == 8'h00);
        lfsr          <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        o_tx_ready    <= !i_stall || lfsr[0];
    end
endmodule

// ===== dv/testbench.sv
`timescale 1ns/1ps
`include "ivf_map.svh"
module testbench
    import ivf_pkg::*;
;
    logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wdata = 32'h0, rdata, pdata = 32'h0, tdata, v;
    logic [31:0] seed = 32'h0000_5af5;
    logic [2:0]  fmt = 3'h7, mode = 3'h0, rate = 3'h4, speed = 3'h0;
    logic [13:0] part = 14'h0001;
    logic [5:0]  chan = 6'h00;
    logic        en = 1'b1, breq = 1'b1, grant = 1'b1, stall = 1'b0;
    logic        pv = 1'b0, psof = 1'b0;
    wire logic   balloc, cyc, pready, tvalid, tlast, tready;
    logic [32:0] rxq[$];
    logic [31:0] pixq[$];
    int          error_cnt = 0, n_checks = 0;

    ivf_framer ivf_framer_i (
        .i_sys_clk(clk), .i_rstn(rstn), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_fmt(fmt), .i_mode(mode), .i_rate(rate), .i_part_quads(part),
        .i_iso_chan(chan), .i_iso_speed(speed), .i_iso_en(en), .i_bw_alloc(balloc),
        .i_cycle_start(cyc), .i_arb_grant(grant), .i_pix_valid(pv), .i_pix_sof(psof),
        .i_pix_data(pdata), .o_pix_ready(pready), .o_tx_valid(tvalid),
        .o_tx_data(tdata), .o_tx_last(tlast), .i_tx_ready(tready)
    );

    ivf_link_model ivf_link_model_i (
        .i_sys_clk(clk), .i_stall(stall), .i_bw_req(breq),
        .o_cycle_start(cyc), .o_bw_alloc(balloc), .o_tx_ready(tready)
    );

    always #50 clk = ~clk;

    // every quadlet the link takes, with its last flag on top
    always @(posedge clk) begin
        if (tvalid === 1'b1 && tready === 1'b1) rxq.push_back({tlast, tdata});
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // msb-first, one bit a step; slow but independent of the design
    function automatic logic [31:0] crc(input logic [31:0] c, input logic [31:0] d);
        for (int i = 31; i >= 0; i--) begin
            c = (c[31] ^ d[i]) ? {c[30:0], 1'b0} ^ `IVF_CRC_POLY : {c[30:0], 1'b0};
        end
        return c;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic rst();
        rstn = 1'b0;
        tick(10);
        rstn = 1'b1;
        tick(5);
        rxq.delete();
        pixq.delete();
    endtask

    task automatic reg_rd(input logic [15:0] a, output logic [31:0] d);
        @(negedge clk);
        rd   = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    task automatic reg_wr(input logic [15:0] a);
        @(negedge clk);
        wr    = 1'b1;
        addr  = a;
        wdata = xs();
        @(negedge clk);
        wr = 1'b0;
    endtask

    // blind pushes ignore ready, so words past a full buffer are lost
    task automatic feed(input int n, input bit sof, input bit blind);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            pv    = 1'b1;
            psof  = sof && i == 0;
            pdata = xs();
            if (blind) @(posedge clk);
            else begin
                do @(posedge clk); while (pready !== 1'b1);
                pixq.push_back(pdata);
            end
        end
        @(negedge clk);
        pv = 1'b0;
    endtask

    task automatic block(input int n, input logic [3:0] sy);
        ivf_hdr_s    h;
        logic [31:0] c, d;
        for (int t = 0; t < 3000 && rxq.size() < n + 3; t++) @(negedge clk);
        h = '{len: 16'(n * 4), tag: `IVF_TAG_VIDEO, chan: chan,
              tcode: `IVF_TCODE_ISO, sy: sy};
        check("header", h, rxq[0][31:0]);
        check("header crc", ~crc(`IVF_CRC_INIT, h), rxq[1][31:0]);
        c = `IVF_CRC_INIT;
        for (int i = 0; i < n; i++) begin
            d = pixq.pop_front();
            c = crc(c, d);
            check("payload", d, rxq[i + 2][31:0]);
        end
        check("data crc", ~c, rxq[n + 2][31:0]);
        for (int i = 0; i < n + 3; i++) begin
            check("last flag", {31'h0, i == n + 2}, {31'h0, rxq[i][32]});
        end
        check("block length", 32'(n + 3), 32'(rxq.size()));
        rxq.delete();
    endtask

    task automatic run(input int n, input bit sof);
        part = 14'(n);
        fork
            feed(n, sof, 1'b0);
            block(n, sof ? `IVF_SY_FIRST : `IVF_SY_OTHER);
        join
    endtask

    // a stalled buffer holds two words; one two-quadlet block carries them off
    task automatic drain();
        grant = 1'b1;
        part  = 14'h0002;
        tick(300);
        check("drained block", 32'd5, 32'(rxq.size()));
        rxq.delete();
        grant = 1'b0;
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // cut a hang well past the few thousand cycles the tests need
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        close_out();
    end

    initial begin
        rst();
        reg_rd(`IVF_TALLY_OFS, v);
        check("tally after reset", `IVF_TALLY_RST, v);
        // table sizes: 160 and 768 quadlets halved four times, 60 doubled once
        fmt  = 3'h0;
        mode = 3'h1;
        rate = 3'h0;
        run(10, 1'b1);
        fmt  = 3'h1;
        mode = 3'h5;
        run(48, 1'b0);
        fmt  = 3'h0;
        mode = 3'h0;
        rate = 3'h5;
        run(120, 1'b1);
        fmt  = 3'h7;
        rate = 3'h4;
        for (int b = 0; b < 6; b++) begin
            chan  = 6'(xs());
            stall = xs() & 32'h1;
            run(1 + int'(xs() % 8), b % 3 == 0);
        end
        stall = 1'b0;
        run(256, 1'b1);
        speed = 3'h1;
        run(257, 1'b0);
        speed = 3'h0;
        // no bandwidth, then a block too big for the speed: period must be skipped
        for (int k = 0; k < 2; k++) begin
            if (k == 0) breq = 1'b0;
            else part = 14'd257;
            feed(1, 1'b0, 1'b0);
            tick(300);
            check("skipped block", 32'h0, 32'(rxq.size()));
            breq = 1'b1;
            part = 14'h0001;
            block(1, `IVF_SY_OTHER);
        end
        // arbitration lost and buffer overrun: one count per frame
        grant = 1'b0;
        feed(6, 1'b1, 1'b1);
        feed(4, 1'b0, 1'b1);
        reg_rd(`IVF_TALLY_OFS, v);
        check("tally one frame", 32'h1, v);
        reg_rd(16'h12f8, v);
        check("unmapped read", 32'h0, v);
        // only an accepted start of frame re-arms the count, so empty the buffer first
        drain();
        feed(4, 1'b1, 1'b1);
        reg_wr(16'h12f8);
        reg_rd(`IVF_TALLY_OFS, v);
        check("tally two frames", 32'h2, v);
        reg_wr(`IVF_TALLY_OFS);
        reg_rd(`IVF_TALLY_OFS, v);
        check("tally cleared", 32'h0, v);
        drain();
        feed(5, 1'b1, 1'b1);
        reg_rd(`IVF_TALLY_OFS, v);
        check("tally before reset", 32'h1, v);
        rst();
        reg_rd(`IVF_TALLY_OFS, v);
        check("tally after reset", 32'h0, v);
        close_out();
    end
endmodule
